// ==== design/bbsr_remap.sv ====
`timescale 1ns/10ps
// boot block swap address remapper, one register stage between the
// processor memory cycle and the boot flash port
module bbsr_remap (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // reset pins from the board, active low, asynchronous to mclk
  input wire logic rtc_well_reset_n,
  input wire logic platform_reset_n,
  // boot block size soft strap, static level
  input wire logic [2:0] boot_block_size,
  // software write of the swap enable bit
  input wire logic swap_en_wr,
  input wire logic swap_en_wdata,
  output logic swap_en,
  // incoming flash cycle
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [31:0] in_addr,
  input wire logic in_write,
  input wire logic [3:0] in_be,
  input wire logic [31:0] in_wdata,
  input wire logic in_firmware_hub_flash,
  // outgoing flash cycle
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_addr,
  output logic out_write,
  output logic [3:0] out_be,
  output logic [31:0] out_wdata,
  output logic out_firmware_hub_flash
);

  // ------------------------------------------------------------
  // swap mask
  // ------------------------------------------------------------
  // returns the xor mask to apply to one address; zero when no swap
  function automatic logic [31:0] swap_mask(
    input logic [31:0] addr,
    input logic en,
    input logic firmware_hub_flash,
    input logic [2:0] code
  );
    logic [31:0] hi;
    int bitpos;
    swap_mask = 32'h0000_0000;
    hi = 32'h0000_0000;
    bitpos = 0;
    if (en && (firmware_hub_flash || code <= bbsr_pkg::STRAP_MAX)) begin
      // fwh fixed on bit 16, spi bit chosen by strap
      if (firmware_hub_flash) begin
        bitpos = bbsr_pkg::FWH_SWAP_BIT;
      end else begin
        bitpos = bbsr_pkg::SPI_BASE_BIT + int'(code);
      end
      hi = 32'hFFFF_FFFF << (bitpos + 1);
      // only the two blocks at the very top of 4 GB are exchanged
      if ((addr & hi) == hi) begin
        swap_mask = 32'h0000_0001 << bitpos;
      end
    end
  endfunction : swap_mask

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic rtc_rst_n_s;
  logic plt_rst_n_s;
  logic [2:0] strap_s;

  bbsr_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_sync_rtc (
    .mclk(mclk),
    .rst(rst),
    .d(rtc_well_reset_n),
    .q(rtc_rst_n_s)
  );

  bbsr_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_sync_plt (
    .mclk(mclk),
    .rst(rst),
    .d(platform_reset_n),
    .q(plt_rst_n_s)
  );

  bbsr_sync #(
    .WIDTH(3),
    .RST_VAL(bbsr_pkg::STRAP_RST)
  ) u_sync_strap (
    .mclk(mclk),
    .rst(rst),
    .d(boot_block_size),
    .q(strap_s)
  );

  // ------------------------------------------------------------
  // swap enable bit
  // ------------------------------------------------------------
  logic swap_en_reg;
  logic rtc_rst_act;
  logic plt_rst_act;

  assign rtc_rst_act = ~rtc_rst_n_s;
  assign plt_rst_act = ~plt_rst_n_s;

  // rtc-well reset dominates a software write in the same cycle; a
  // platform reset deliberately leaves the bit alone so a half-done
  // boot block update still boots from the good copy
  always_ff @(posedge mclk) begin
    if (rst || rtc_rst_act) begin
      swap_en_reg <= bbsr_pkg::SWAP_EN_RST;
    end else if (swap_en_wr) begin
      swap_en_reg <= swap_en_wdata;
    end
  end

  assign swap_en = swap_en_reg;

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  logic [2:0] strap_reg;

  // strap is re-read while the platform sits in reset, frozen otherwise,
  // so a glitch on the strap net never moves the decode mid-boot
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_reg <= bbsr_pkg::STRAP_RST;
    end else if (plt_rst_act) begin
      strap_reg <= strap_s;
    end
  end

  // ------------------------------------------------------------
  // cycle stage
  // ------------------------------------------------------------
  logic out_valid_reg;
  logic [31:0] out_addr_reg;
  logic out_write_reg;
  logic [3:0] out_be_reg;
  logic [31:0] out_wdata_reg;
  logic out_fwh_reg;
  logic fire;
  logic [31:0] mask_now;

  // stage can take a new cycle when empty or draining this edge
  assign in_ready = ~out_valid_reg | out_ready;
  assign fire = in_valid & in_ready;
  assign mask_now = swap_mask(in_addr, swap_en_reg, in_firmware_hub_flash,
                              strap_reg);

  // valid flag; platform reset drops any cycle in flight
  always_ff @(posedge mclk) begin
    if (rst || plt_rst_act) begin
      out_valid_reg <= 1'b0;
    end else if (in_ready) begin
      out_valid_reg <= in_valid;
    end
  end

  // payload: only the address is altered, reads and writes alike
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_addr_reg <= 32'h0000_0000;
      out_write_reg <= 1'b0;
      out_be_reg <= 4'h0;
      out_wdata_reg <= 32'h0000_0000;
      out_fwh_reg <= 1'b0;
    end else if (fire) begin
      out_addr_reg <= in_addr ^ mask_now;
      out_write_reg <= in_write;
      out_be_reg <= in_be;
      out_wdata_reg <= in_wdata;
      out_fwh_reg <= in_firmware_hub_flash;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_addr = out_addr_reg;
  assign out_write = out_write_reg;
  assign out_be = out_be_reg;
  assign out_wdata = out_wdata_reg;
  assign out_firmware_hub_flash = out_fwh_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic spi_on;
  assign spi_on = fire & swap_en_reg & ~in_firmware_hub_flash;

  a_fwh_bit16_flip: assert property (
    fire && swap_en_reg && in_firmware_hub_flash &&
    (in_addr[31:17] == 15'h7FFF)
    |=> out_addr == ($past(in_addr) ^ 32'h0001_0000))
    else $error("fwh cycle in top blocks did not flip bit 16");

  a_fwh_top_route: assert property (
    fire && swap_en_reg && in_firmware_hub_flash && !plt_rst_act &&
    (in_addr[31:16] == 16'hFFFF)
    |=> out_valid && (out_addr[31:16] == 16'hFFFE) &&
        (out_addr[15:0] == $past(in_addr[15:0])))
    else $error("fwh top block not routed to lower block");

  a_off_passthru: assert property (
    fire && !swap_en_reg && !plt_rst_act
    |=> out_valid && (out_addr == $past(in_addr)))
    else $error("address changed while swap disabled");

  a_spi_64k: assert property (
    spi_on && (strap_reg == 3'h0) && (in_addr[31:16] == 16'hFFFE)
    |=> out_addr[31:16] == 16'hFFFF)
    else $error("64 KB swap lower block not sent up");

  a_spi_128k: assert property (
    spi_on && (strap_reg == 3'h1) && (in_addr[31:17] == 15'h7FFF)
    |=> out_addr[31:17] == 15'h7FFE)
    else $error("128 KB swap top region not sent down");

  a_spi_256k: assert property (
    spi_on && (strap_reg == 3'h2) && (in_addr[31:18] == 14'h3FFE)
    |=> out_addr[31:18] == 14'h3FFF)
    else $error("256 KB swap lower region not sent up");

  a_spi_512k: assert property (
    spi_on && (strap_reg == 3'h3) && (in_addr[31:19] == 13'h1FFF)
    |=> out_addr[31:19] == 13'h1FFE)
    else $error("512 KB swap top region not sent down");

  a_spi_1m: assert property (
    spi_on && (strap_reg == 3'h4) && (in_addr[31:20] == 12'hFFE)
    |=> out_addr[31:20] == 12'hFFF)
    else $error("1 MB swap lower region not sent up");

  a_spi_strap_bit: assert property (
    spi_on && (strap_reg <= 3'h4) && (in_addr[31:21] == 11'h7FF)
    |=> (out_addr ^ $past(in_addr)) ==
        (32'h0001_0000 << $past(strap_reg)))
    else $error("spi flipped bit does not follow strap");

  a_rtc_clears: assert property (
    rtc_rst_act |=> !swap_en ##1 (!swap_en || $past(swap_en_wr)))
    else $error("swap enable survived rtc-well reset");

  a_plt_keeps: assert property (
    plt_rst_act && !rtc_rst_act && !swap_en_wr
    |=> $stable(swap_en))
    else $error("platform reset disturbed swap enable");

  // a software write racing an rtc-well reset must lose
  a_rtc_write_lost: assert property (
    rtc_rst_act && swap_en_wr
    |=> !swap_en)
    else $error("write won over rtc-well reset");

  // platform reset flushes the stage so no stale cycle leaks out
  a_plt_flush: assert property (
    plt_rst_act
    |=> !out_valid)
    else $error("cycle survived platform reset");

  a_fwh_outside: assert property (
    fire && in_firmware_hub_flash && (in_addr[31:17] != 15'h7FFF)
    |=> out_addr == $past(in_addr))
    else $error("fwh address outside top blocks was changed");

  a_payload_kept: assert property (
    fire |=> (out_wdata == $past(in_wdata)) && (out_be == $past(in_be)) &&
             (out_write == $past(in_write)) &&
             (out_firmware_hub_flash == $past(in_firmware_hub_flash)))
    else $error("cycle type, data or byte enables altered");

  a_bad_strap: assert property (
    spi_on && (strap_reg > 3'h4) |=> out_addr == $past(in_addr))
    else $error("reserved strap code caused a swap");

  a_stall_hold: assert property (
    out_valid && !out_ready && !plt_rst_act
    |=> out_valid && $stable(out_addr) && $stable(out_wdata))
    else $error("stalled cycle changed before it was taken");

  // ------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------
  c_fwh_swap: cover property (
    fire && swap_en_reg && in_firmware_hub_flash && mask_now != 32'h0);

  c_spi_1m_swap: cover property (
    spi_on && strap_reg == 3'h4 && mask_now != 32'h0);

  c_swap_write: cover property (
    fire && in_write && mask_now != 32'h0);

  c_stall: cover property (out_valid && !out_ready ##1 out_ready);

  // rtc-well reset arriving while the swap is on
  c_rtc_clear: cover property (rtc_rst_act && swap_en_reg);

endmodule : bbsr_remap

// ==== design/bbsr_pkg.sv ====
package bbsr_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int STRAP_W = 3;

  // ------------------------------------------------------------
  // swap geometry
  // ------------------------------------------------------------
  // firmware hub always swaps on bit 16 (two 64-KB blocks)
  localparam int FWH_SWAP_BIT = 16;
  // smallest SPI boot block is 64 KB, i.e. bit 16
  localparam int SPI_BASE_BIT = 16;
  // largest legal boot block size code (1 MB)
  localparam logic [2:0] STRAP_MAX = 3'h4;
  // always-on boot decode range is the top 512 KB (bits 31:19 all ones)
  localparam int TOP_DECODE_BIT = 19;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic SWAP_EN_RST = 1'b0;
  localparam logic [2:0] STRAP_RST = 3'h0;
  localparam int SYNC_STAGES = 2;

endpackage : bbsr_pkg

// ==== design/bbsr_sync.sv ====
`timescale 1ns/10ps
// two-flop synchroniser for levels arriving from pins
module bbsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // first flop feeds only the second one
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : bbsr_sync

// ==== sim/bbsr_flash_model.sv ====
`timescale 1ns/10ps
// ------------------------------
// boot flash stand-in
// ------------------------------
module bbsr_flash_model (
  // clock, reset, stall control
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  // cycle from the remapper
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [31:0] out_addr,
  input wire logic out_write,
  input wire logic [3:0] out_be,
  input wire logic [31:0] out_wdata,
  input wire logic out_firmware_hub_flash,
  // last cycle taken, and count
  output logic [31:0] got_addr,
  output logic got_write,
  output logic [3:0] got_be,
  output logic [31:0] got_wdata,
  output logic got_fwh,
  output logic [7:0] got_cnt
);
  // ready lags stall by an edge, as a busy flash would
  always @(posedge mclk) out_ready <= !stall && !rst;
  // take the cycle at the handshake edge
  always @(posedge mclk) begin
    if (rst) begin
      got_cnt <= 8'h00;
    end else if (out_valid && out_ready) begin
      got_cnt <= got_cnt + 8'h01;
      got_addr <= out_addr;
      got_write <= out_write;
      got_be <= out_be;
      got_wdata <= out_wdata;
      got_fwh <= out_firmware_hub_flash;
    end
  end
endmodule : bbsr_flash_model

// ==== sim/tb_bbsr_remap.sv ====
`timescale 1ns/10ps
module tb_bbsr_remap;
  // ------------------------------
  // signals
  // ------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rtc_n = 1'b1;
  logic plt_n = 1'b1;
  logic [2:0] strap = 3'h0;
  logic wr = 1'b0;
  logic wd = 1'b0;
  logic in_valid = 1'b0;
  logic in_write = 1'b0;
  logic in_fwh = 1'b0;
  logic [3:0] in_be = 4'hF;
  logic [31:0] in_addr = 32'h0;
  logic [31:0] in_wdata = 32'h0;
  logic stall = 1'b0;
  logic swap_en, in_ready, out_valid, out_ready, out_write, out_fwh;
  logic got_write, got_fwh;
  logic [3:0] out_be, got_be;
  logic [31:0] out_addr, out_wdata, got_addr, got_wdata;
  logic [7:0] got_cnt;
  logic [7:0] sent = 8'h00;
  int bad_count = 0;
  int n_checks = 0;

  always #2.5 mclk = ~mclk;

  bbsr_remap i_bbsr_remap (.mclk(mclk), .rst(rst),
    .rtc_well_reset_n(rtc_n), .platform_reset_n(plt_n),
    .boot_block_size(strap), .swap_en_wr(wr), .swap_en_wdata(wd),
    .swap_en(swap_en), .in_valid(in_valid), .in_ready(in_ready),
    .in_addr(in_addr), .in_write(in_write), .in_be(in_be),
    .in_wdata(in_wdata), .in_firmware_hub_flash(in_fwh),
    .out_valid(out_valid), .out_ready(out_ready), .out_addr(out_addr),
    .out_write(out_write), .out_be(out_be), .out_wdata(out_wdata),
    .out_firmware_hub_flash(out_fwh));

  bbsr_flash_model i_bbsr_flash_model (.mclk(mclk), .rst(rst),
    .stall(stall), .out_valid(out_valid), .out_ready(out_ready),
    .out_addr(out_addr), .out_write(out_write), .out_be(out_be),
    .out_wdata(out_wdata), .out_firmware_hub_flash(out_fwh),
    .got_addr(got_addr), .got_write(got_write), .got_be(got_be),
    .got_wdata(got_wdata), .got_fwh(got_fwh), .got_cnt(got_cnt));

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout;
    bad_count++;
    $display("MISMATCH at %0t: wait ran out", $time);
    print_verdict();
  endtask : timeout

  // hold the request until a negedge shows ready, release after take
  task automatic send(input logic [31:0] a, input logic f,
                      input logic w, input logic [3:0] be,
                      input logic [31:0] d);
    int k;
    @(posedge mclk);
    in_valid <= 1'b1;
    in_addr <= a;
    in_fwh <= f;
    in_write <= w;
    in_be <= be;
    in_wdata <= d;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (in_ready !== 1'b1 && k < 20);
    if (k >= 20) timeout();
    @(posedge mclk);
    in_valid <= 1'b0;
  endtask : send

  task automatic receive;
    int k;
    sent = sent + 8'h01;
    k = 0;
    while (got_cnt !== sent && k < 20) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 20) timeout();
  endtask : receive

  task automatic xfer(input logic [31:0] a, input logic f);
    send(a, f, 1'b0, 4'hF, 32'h0);
    receive();
  endtask : xfer

  task automatic set_swap(input logic v);
    @(posedge mclk);
    wr <= 1'b1;
    wd <= v;
    @(posedge mclk);
    wr <= 1'b0;
    @(negedge mclk);
  endtask : set_swap

  // strap is only taken while platform reset is held
  task automatic set_strap(input logic [2:0] s);
    @(posedge mclk);
    plt_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge mclk);
    plt_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : set_strap

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_off;
    for (int f = 0; f < 2; f++) begin
      xfer(32'hFFFF_1234, f[0]);
      check(got_addr, 32'hFFFF_1234);
    end
  endtask : t_off

  task automatic t_fwh;
    set_swap(1'b1);
    check(32'(swap_en), 32'h1);
    xfer(32'hFFFF_1234, 1'b1);
    check(got_addr, 32'hFFFE_1234);
    xfer(32'hFFFE_0010, 1'b1);
    check(got_addr, 32'hFFFF_0010);
    xfer(32'hFFFD_5678, 1'b1);
    check(got_addr, 32'hFFFD_5678);
  endtask : t_fwh

  // every strap code, both directions of each exchange
  task automatic t_spi;
    logic [31:0] m;
    for (int s = 0; s < 8; s++) begin
      set_strap(s[2:0]);
      check(32'(swap_en), 32'h1);
      m = (s <= 4) ? (32'h1 << (16 + s)) : 32'h0;
      xfer(32'hFFFF_FFF0, 1'b0);
      check(got_addr, 32'hFFFF_FFF0 ^ m);
      xfer(32'hFFFF_FFF0 ^ m, 1'b0);
      check(got_addr, 32'hFFFF_FFF0);
    end
  endtask : t_spi

  // write held in the stage while the flash stalls
  task automatic t_stall;
    @(posedge mclk);
    stall <= 1'b1;
    send(32'hFFFF_0000, 1'b1, 1'b1, 4'hA, 32'h5A5A_C3C3);
    repeat (3) @(negedge mclk);
    check(32'({out_valid, in_ready}), 32'h2);
    @(posedge mclk);
    stall <= 1'b0;
    receive();
    check(got_addr, 32'hFFFE_0000);
    check(32'({got_write, got_be}), 32'h1A);
    check(got_wdata, 32'h5A5A_C3C3);
    check(32'(got_fwh), 32'h1);
  endtask : t_stall

  // a write during RTC-well reset loses; cleared bit disables swap
  task automatic t_rtc;
    @(posedge mclk);
    rtc_n <= 1'b0;
    repeat (4) @(posedge mclk);
    set_swap(1'b1);
    check(32'(swap_en), 32'h0);
    @(posedge mclk);
    rtc_n <= 1'b1;
    repeat (3) @(posedge mclk);
    xfer(32'hFFFF_1234, 1'b1);
    check(got_addr, 32'hFFFF_1234);
  endtask : t_rtc

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_off();
    t_fwh();
    t_spi();
    t_stall();
    t_rtc();
    print_verdict();
  end
endmodule : tb_bbsr_remap
